// ==== dual_page_translator.sv ====
`timescale 1ns/100ps
`include "page_xlate_params.svh"

// Notes on behaviour
// - master serves physical pages 0..127, slave serves 128..255
// - bank choice is fixed on the first clock after reset release from the byte/word input
// - each page spans 32 kbytes; each manager drives 4 Mbytes
// - master pages start at 0x2000000, slave pages at 0x2400000
// - physical region accesses allowed in supervisor mode only
// - bottom 32 Mbytes are logical pages translated with three protection levels
// - logical access reaches memory only with mapping and enough privilege
// - missing mapping or privilege votes abort and starts no memory cycle
// - translation entries start undefined and are writable in supervisor mode only
// - translator writes use address bus; bit 7 picks master or slave
// - combined abort needs both translators voting abort
// - abort for illegal mode access, valid before phase one ends
// - manager is write only; reads in shared region go elsewhere
// - manager generates phase one and phase two processor clocks
// - page mode cycles keep the row open for same-row accesses
// - byte/word sampled at reset release: high master, low slave
module dual_page_translator #(
   parameter int BANK_PAGES = 128,
   parameter int LPN_W      = 10,
   parameter int ROW_W      = 10
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_byte_word,
   input  wire logic [25:0] i_addr,
   input  wire logic        i_read_write,
   input  wire logic        i_memory_request_n,
   input  wire logic        i_translate_n,
   input  wire logic        i_os_mode,
   input  wire logic        i_partner_vote,
   output logic             o_phase_one_clock,
   output logic             o_phase_two_clock,
   output logic             o_abort_vote,
   output logic             o_abort,
   output logic             o_is_master,
   output logic             o_ras_n,
   output logic             o_cas_n,
   output logic             o_dram_we_n,
   output logic [9:0]       o_dram_addr
);

   // counter steps per phase, and the last step of one processor cycle
   localparam logic [2:0] PH_LEN  = 3'(`PHASE_CYC);
   localparam logic [2:0] CYC_END = 3'(2 * `PHASE_CYC - 1);

   if (BANK_PAGES != 128 || LPN_W != 10 || ROW_W != 10 || `PHASE_CYC > 4) begin : g_check
      $error("dual_page_translator needs 128 pages, 10-bit pages and rows, short phases");
   end

   // whole manager state, then decode and translation results
   page_xlate_pkg::mgr_state_s s;
   page_xlate_pkg::mgr_state_s nxt;
   logic [25:0]                a;
   logic                       is_log;
   logic                       is_phys;
   logic                       is_undef;
   logic                       is_shared;
   logic                       own_bank;
   logic                       xw_en;
   logic                       hit;
   logic                       allowed;
   logic [6:0]                 hit_ppn;
   logic [19:0]                word_addr;

   // region decode of the latched request
   always_comb begin
      a         = s.req.addr;
      is_log    = a < `PHYS_BASE;
      is_phys   = (a >= `PHYS_BASE) && (a < `IO_BASE);
      is_undef  = a >= `PHYS_UNDEF;
      is_shared = a >= `SHARED_BASE;
      own_bank  = (a < `SLAVE_BASE) == s.is_master;
      xw_en     = (s.cnt == 3'h0) && s.req.valid && is_shared && s.req.rw
                  && !s.req.user && (a >= `XLATE_WR_BASE)
                  && (a[`XW_BANK_BIT] == !s.is_master);
   end

   // this manager's translator bank, indexed by physical page
   page_xlate_cam #(
      .PAGES (BANK_PAGES),
      .LPN_W (LPN_W)
   ) u_cam (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_wr_en   (xw_en),
      .i_wr_ppn  (a[6:0]),
      .i_wr_lpn  (a[`XW_LPN_LSB +: 10]),
      .i_wr_prot (a[`XW_PROT_LSB +: 2]),
      .i_lpn     (a[`PAGE_LSB +: 10]),
      .i_rw      (s.req.rw),
      .i_user    (s.req.user),
      .i_os      (s.req.os),
      .o_hit     (hit),
      .o_allowed (allowed),
      .o_ppn     (hit_ppn)
   );

   // 32 kbyte page, word offset inside it; bank-local word address
   assign word_addr = {(is_log ? hit_ppn : a[21:15]), a[14:`WORD_LSB]};

   // whole processor cycle sequencing; one ref clock per counter step
   always_comb begin
      nxt     = s;
      nxt.cnt = (s.cnt == CYC_END) ? 3'h0 : s.cnt + 3'h1;
      nxt.ph1 = nxt.cnt < PH_LEN;
      nxt.ph2 = nxt.cnt >= PH_LEN;
      // strap caught on the first edge after release, never under reset
      if (!s.strap_done) begin
         nxt.strap_done = 1'b1;
         nxt.is_master  = i_byte_word;
      end
      // end of phase two: take next request, close the previous transfer
      if (s.cnt == CYC_END) begin
         nxt.req.valid = !i_memory_request_n && s.strap_done;
         nxt.req.addr  = i_addr;
         nxt.req.rw    = i_read_write;
         nxt.req.user  = !i_translate_n;
         nxt.req.os    = i_os_mode;
         nxt.cas_n     = 1'b1;
         nxt.we_n      = 1'b1;
         nxt.abort     = 1'b0;
         nxt.go        = 1'b0;
      end
      // translate and vote
      if (s.cnt == 3'h0) begin
         nxt.vote = 1'b0;
         nxt.go   = 1'b0;
         if (s.req.valid) begin
            if (is_log) begin
               nxt.vote = !(hit && allowed);
               nxt.go   = hit && allowed;
            end else if (is_phys) begin
               nxt.vote = s.req.user;
               nxt.go   = !s.req.user && own_bank && !is_undef;
            end else if (is_shared) begin
               nxt.vote = s.req.rw && s.req.user;
            end
         end
         nxt.acc_col = word_addr[9:0];
         // page mode: keep the row when it is already open
         if (nxt.go && (s.ras_n || s.open_row != word_addr[19:10])) begin
            nxt.ras_n    = 1'b1;
            nxt.open_row = word_addr[19:10];
         end
      end
      // combine with the partner and open the row if needed
      if (s.cnt == 3'h1) begin
         nxt.abort = s.vote && i_partner_vote;
         if (s.go && s.ras_n) begin
            nxt.ras_n     = 1'b0;
            nxt.dram_addr = s.open_row;
         end
      end
      // column strobe, only once no abort can stand against it
      if (s.cnt == 3'h2 && s.go) begin
         nxt.dram_addr = s.acc_col;
         nxt.cas_n     = 1'b0;
         nxt.we_n      = !s.req.rw;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // start on the last step so the first phase one after reset is full width
         s           <= '0;
         s.cnt       <= CYC_END;
         s.ras_n     <= 1'b1;
         s.cas_n     <= 1'b1;
         s.we_n      <= 1'b1;
         s.open_row  <= `ROW_RESET;
         s.dram_addr <= `ROW_RESET;
      end else begin
         s <= nxt;
      end
   end

   // outputs straight from the state register
   assign o_phase_one_clock = s.ph1;
   assign o_phase_two_clock = s.ph2;
   assign o_abort_vote      = s.vote;
   assign o_abort           = s.abort;
   assign o_is_master       = s.is_master;
   assign o_ras_n           = s.ras_n;
   assign o_cas_n           = s.cas_n;
   assign o_dram_we_n       = s.we_n;
   assign o_dram_addr       = s.dram_addr;

   // checks run on the reference clock and sleep while reset is low
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   sequence s_ph1_run;
      o_phase_one_clock [*3] ##1 !o_phase_one_clock;
   endsequence

   sequence s_user_phys;
      s.cnt == 3'h0 && s.req.valid && is_phys && s.req.user;
   endsequence

   sequence s_bad_logical;
      s.cnt == 3'h0 && s.req.valid && is_log && !(hit && allowed);
   endsequence

   sequence s_same_row_hit;
      s.cnt == 3'h0 && nxt.go && !s.ras_n && s.open_row == word_addr[19:10];
   endsequence

   sequence s_ph2_run;
      o_phase_two_clock [*3] ##1 !o_phase_two_clock;
   endsequence

   sequence s_cas_burst;
      !o_cas_n [*3] ##1 o_cas_n;
   endsequence

   // phase one stays up for one whole phase, then drops
   AST_PH1_WIDTH: assert property ($rose(o_phase_one_clock) |-> s_ph1_run)
      else $error("phase one clock width wrong");

   // phase two likewise; a runt phase would starve the processor
   AST_PH2_WIDTH: assert property ($rose(o_phase_two_clock) |-> s_ph2_run)
      else $error("phase two clock width wrong");

   // phase two opens exactly one phase after phase one
   AST_PH_ORDER: assert property (
      $rose(o_phase_one_clock) |-> ##3 $rose(o_phase_two_clock))
      else $error("phase two did not follow phase one");

   // the two processor clocks never overlap
   AST_NO_OVERLAP: assert property (!(o_phase_one_clock && o_phase_two_clock))
      else $error("phase clocks overlap");

   // combined abort is the and of both votes, one step later
   AST_ABORT_AND: assert property ((s.cnt == 3'h1) |=>
      (o_abort == $past(o_abort_vote && i_partner_vote)))
      else $error("combined abort not the and of both votes");

   // abort must reach the processor while phase one is still high
   AST_ABORT_PH1: assert property ($rose(o_abort) |-> o_phase_one_clock && s.cnt == 3'h2)
      else $error("abort raised outside phase one");

   // abort is gone as the next processor cycle opens
   AST_ABORT_CLEAR: assert property ((s.cnt == CYC_END) |=> !o_abort)
      else $error("abort held into the next processor cycle");

   // the vote only moves on the translate step
   AST_VOTE_HOLD: assert property ((s.cnt != 3'h0) |=> $stable(o_abort_vote))
      else $error("abort vote moved inside a processor cycle");

   // no column strobe behind a vote
   AST_NO_ACCESS: assert property ($fell(o_cas_n) |-> !o_abort_vote && !o_abort)
      else $error("memory cycle started on an aborted access");

   // user mode is kept out of the physical region for the whole cycle
   AST_SUPER_PHYS: assert property (s_user_phys |=> o_abort_vote [*5])
      else $error("user physical access not voted for abort");

   // unmapped or forbidden logical page votes and never strobes
   AST_XLATE_GATE: assert property (
      s_bad_logical |=> (o_abort_vote && !s.go) ##2 o_cas_n [*3])
      else $error("unmapped logical access reached memory");

   // the partner's bank is left to the partner
   AST_OWN_BANK: assert property ((s.cnt == 3'h0 && is_phys && !own_bank) |=> !s.go ##2 o_cas_n)
      else $error("foreign bank access driven");

   // translator writes never vote and never start a memory cycle
   AST_XW_QUIET: assert property (xw_en |=> !o_abort_vote && !s.go)
      else $error("translator write treated as a memory access");

   // page mode keeps the row strobe down across a same-row access
   AST_PAGE_MODE: assert property (s_same_row_hit |=> !o_ras_n [*5])
      else $error("open row closed on a same-row access");

   // row address stands on the bus as the row strobe falls
   AST_ROW_ADDR: assert property ($fell(o_ras_n) |-> o_dram_addr == s.open_row)
      else $error("row strobe fell without the row address");

   // column strobe only behind an open row, for three steps
   AST_ROW_FIRST: assert property ($fell(o_cas_n) |-> !o_ras_n)
      else $error("column strobe without an open row");
   AST_CAS_WIDTH: assert property ($fell(o_cas_n) |-> s_cas_burst)
      else $error("column strobe width wrong");

   // write enable only inside a column strobe
   AST_WE_IN_CAS: assert property (!o_dram_we_n |-> !o_cas_n)
      else $error("write enable outside a column strobe");

   // role taken from the byte/word input at release, then frozen
   AST_STRAP_TAKE: assert property (
      $rose(s.strap_done) |-> o_is_master == $past(i_byte_word))
      else $error("master strap not taken at reset release");
   AST_STRAP_HOLD: assert property ((s.strap_done && $past(s.strap_done)) |-> $stable(o_is_master))
      else $error("master strap changed after reset");

endmodule

// ==== dual_page_translator_tb.sv ====
`timescale 1ns/100ps

module dual_page_translator_tb;
   logic        i_ref_clk;
   logic        i_rst_b;
   logic        bw_m;
   logic [25:0] addr;
   logic        rw, memory_request_n_n, tn, os;
   logic        ph1_m, ph2_m, vote_m, vote_s, abort_m, abort_s, mst_m, mst_s;
   logic        ras_m, cas_m, ras_s, cas_s, ras_hi, we_m, we_s;
   logic [9:0]  da_m, da_s;
   int          fail_count;
   int          compares;

   dual_page_translator dut (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_byte_word(bw_m), .i_addr(addr),
      .i_read_write(rw), .i_memory_request_n(memory_request_n_n), .i_translate_n(tn), .i_os_mode(os),
      .i_partner_vote(vote_s), .o_phase_one_clock(ph1_m), .o_phase_two_clock(ph2_m),
      .o_abort_vote(vote_m), .o_abort(abort_m), .o_is_master(mst_m), .o_ras_n(ras_m),
      .o_cas_n(cas_m), .o_dram_we_n(we_m), .o_dram_addr(da_m));

   dual_page_translator dut_slv (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_byte_word(1'b0), .i_addr(addr),
      .i_read_write(rw), .i_memory_request_n(memory_request_n_n), .i_translate_n(tn), .i_os_mode(os),
      .i_partner_vote(vote_m), .o_phase_one_clock(), .o_phase_two_clock(),
      .o_abort_vote(vote_s), .o_abort(abort_s), .o_is_master(mst_s), .o_ras_n(ras_s),
      .o_cas_n(cas_s), .o_dram_we_n(we_s), .o_dram_addr(da_s));

   // processor runs off the master's phase two clock
   processor_model cpu (
      .i_ref_clk(i_ref_clk), .i_phase_two_clock(ph2_m), .o_addr(addr), .o_read_write(rw),
      .o_opcode_fetch_n(), .o_memory_request_n(memory_request_n_n), .o_translate_n(tn), .o_os_mode(os));

   initial i_ref_clk = 1'b0;
   always #12.5 i_ref_clk = ~i_ref_clk;

   task automatic check_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         $display("unexpected %s expected %b seen %b", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // logical address and translator write encodings
   function automatic logic [25:0] la(input logic [9:0] lpn, input logic [14:0] off);
      return {1'b0, lpn, off};
   endfunction

   function automatic logic [25:0] xw(input logic [9:0] lpn, input logic [1:0] prot,
                                      input logic bank, input logic [6:0] ppn);
      return {3'b111, lpn, 3'b000, prot, bank, ppn};
   endfunction

   // one processor cycle; abort must show while phase one is still high
   task automatic run(input logic [25:0] a, input int w, input int t, input int o,
                      input int ab, input int cm, input int cs);
      logic       ab_m, ab_s, hit_m, hit_s, wr_m, wr_s;
      logic [9:0] col_m, col_s;
      int         n;
      ab_m = 1'b0;
      ab_s = 1'b0;
      hit_m = 1'b0;
      hit_s = 1'b0;
      col_m = 10'h000;
      col_s = 10'h000;
      ras_hi = 1'b0;
      wr_m = 1'b1;
      wr_s = 1'b1;
      @(posedge i_ref_clk);
      cpu.post(a, w != 0, t != 0, o != 0);
      n = 0;
      while (cpu.pend === 1'b1 && n < 40) begin
         @(negedge i_ref_clk);
         n++;
      end
      if (n >= 40) begin
         fail_count++;
         give_verdict();
      end
      repeat (10) begin
         @(negedge i_ref_clk);
         ab_m = ab_m | (abort_m & ph1_m);
         ab_s = ab_s | (abort_s & ph1_m);
         ras_hi = ras_hi | (ras_m === 1'b1);
         if (cas_m === 1'b0) begin
            hit_m = 1'b1;
            col_m = da_m;
            wr_m  = we_m;
         end
         if (cas_s === 1'b0) begin
            hit_s = 1'b1;
            col_s = da_s;
            wr_s  = we_s;
         end
      end
      check_bit("abort master", ab != 0, ab_m);
      check_bit("abort slave", ab != 0, ab_s);
      check_bit("access master", cm != 0, hit_m);
      check_bit("access slave", cs != 0, hit_s);
      if (cm != 0) check_val("column master", a[11:2], col_m);
      if (cs != 0) check_val("column slave", a[11:2], col_s);
      if (cm != 0) check_bit("write strobe master", w == 0, wr_m);
      if (cs != 0) check_bit("write strobe slave", w == 0, wr_s);
   endtask

   task automatic t_reset();
      logic [9:0] n1, n2, nb;
      n1 = 10'h000;
      n2 = 10'h000;
      nb = 10'h000;
      @(negedge i_ref_clk);
      bw_m = 1'b0; // strap must already be latched
      repeat (12) begin
         @(negedge i_ref_clk);
         n1 = n1 + 10'(ph1_m === 1'b1);
         n2 = n2 + 10'(ph2_m === 1'b1);
         nb = nb + 10'(ph1_m === 1'b1 && ph2_m === 1'b1);
      end
      check_bit("master strap", 1'b1, mst_m);
      check_bit("slave strap", 1'b0, mst_s);
      check_val("phase one count", 10'h006, n1);
      check_val("phase two count", 10'h006, n2);
      check_val("phase overlap", 10'h000, nb);
      $display("test reset done");
   endtask

   task automatic t_logical();
      // distinct logical pages, 32k pages of a 1024 page space
      run(xw(10'h005, 2'b00, 1'b0, 7'h03), 1, 1, 0, 0, 0, 0);
      run(xw(10'h006, 2'b01, 1'b1, 7'h04), 1, 1, 0, 0, 0, 0);
      run(xw(10'h007, 2'b10, 1'b0, 7'h09), 1, 1, 0, 0, 0, 0);
      run(la(10'h005, 15'h0124), 0, 0, 0, 0, 1, 0);
      run(la(10'h006, 15'h0a48), 0, 0, 0, 0, 0, 1);
      run(la(10'h006, 15'h0a48), 1, 0, 0, 1, 0, 0);
      run(la(10'h009, 15'h0000), 0, 0, 0, 1, 0, 0);
      run(la(10'h007, 15'h0010), 0, 0, 0, 1, 0, 0);
      run(la(10'h007, 15'h0010), 0, 0, 1, 0, 1, 0);
      run(la(10'h007, 15'h0010), 1, 0, 1, 1, 0, 0);
      run(xw(10'h005, 2'b10, 1'b0, 7'h03), 1, 1, 0, 0, 0, 0);
      run(la(10'h005, 15'h0124), 0, 0, 0, 1, 0, 0);
      $display("test logical done");
   endtask

   task automatic t_physical();
      run(26'h2010124, 0, 1, 0, 0, 1, 0);
      run(26'h2408248, 1, 1, 0, 0, 0, 1);
      run(26'h2000040, 0, 0, 0, 1, 0, 0);
      run(26'h2800010, 0, 1, 0, 0, 0, 0);
      run(26'h3400000, 0, 1, 0, 0, 0, 0);
      run(26'h3400000, 1, 0, 0, 1, 0, 0);
      $display("test physical done");
   endtask

   task automatic t_page();
      run(xw(10'h005, 2'b00, 1'b0, 7'h03), 1, 1, 0, 0, 0, 0);
      run(la(10'h005, 15'h0200), 0, 0, 0, 0, 1, 0);
      run(la(10'h005, 15'h0204), 0, 0, 0, 0, 1, 0);
      check_bit("row kept open", 1'b0, ras_hi);
      $display("test page mode done");
   endtask

   initial begin
      i_rst_b = 1'b0;
      bw_m = 1'b1;
      fail_count = 0;
      compares = 0;
      repeat (16) @(negedge i_ref_clk);
      i_rst_b = 1'b1;
      t_reset();
      t_logical();
      t_physical();
      t_page();
      give_verdict();
   end
endmodule

// ==== page_xlate_cam.sv ====
`timescale 1ns/100ps
`include "page_xlate_params.svh"

module page_xlate_cam #(
   parameter int PAGES = 128,
   parameter int LPN_W = 10
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_wr_en,
   input  wire logic [6:0]       i_wr_ppn,
   input  wire logic [LPN_W-1:0] i_wr_lpn,
   input  wire logic [1:0]       i_wr_prot,
   input  wire logic [LPN_W-1:0] i_lpn,
   input  wire logic             i_rw,
   input  wire logic             i_user,
   input  wire logic             i_os,
   output logic                  o_hit,
   output logic                  o_allowed,
   output logic [6:0]            o_ppn
);

   if (PAGES != 128 || LPN_W != 10) begin : g_check
      $error("page_xlate_cam serves exactly 128 pages of 10-bit logical numbers");
   end

   page_xlate_pkg::cam_state_s   st_ff;
   page_xlate_pkg::cam_state_s   nxt_st;
   page_xlate_pkg::xlate_entry_s table_q [PAGES];
   logic [PAGES-1:0]             match;
   logic [1:0]                   hit_prot;

   // contents stay unset until software writes them; only the valid bits reset
   always_ff @(posedge i_ref_clk) begin
      if (i_wr_en) begin
         table_q[i_wr_ppn] <= '{lpn: i_wr_lpn, prot: i_wr_prot};
      end
   end

   always_comb begin
      nxt_st = st_ff;
      if (i_wr_en) begin
         nxt_st.valid[i_wr_ppn] = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // one comparator per physical page
   for (genvar g = 0; g < PAGES; g++) begin : g_match
      assign match[g] = st_ff.valid[g] && (table_q[g].lpn == i_lpn);
   end

   // software keeps each logical page unique, so the lowest hit is the only one
   always_comb begin
      o_hit    = 1'b0;
      o_ppn    = `PPN_RESET;
      hit_prot = 2'b11;
      for (int i = PAGES - 1; i >= 0; i--) begin
         if (match[i]) begin
            o_hit    = 1'b1;
            o_ppn    = 7'(i);
            hit_prot = table_q[i].prot;
         end
      end
   end

   // three privilege levels: supervisor, os, user
   always_comb begin
      if (!i_user) begin
         o_allowed = 1'b1;
      end else if (i_os) begin
         o_allowed = !hit_prot[1] || !i_rw;
      end else begin
         o_allowed = (hit_prot == 2'b00) || (hit_prot == 2'b01 && !i_rw);
      end
   end

endmodule

// ==== page_xlate_params.svh ====
`ifndef PAGE_XLATE_PARAMS_SVH
`define PAGE_XLATE_PARAMS_SVH

// reference clock and processor phase timing
`define REF_CLK_NS     25
`define PHASE_NS       75
`define PHASE_CYC      ((`PHASE_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

// address map boundaries
`define PHYS_BASE      26'h2000000
`define SLAVE_BASE     26'h2400000
`define PHYS_UNDEF     26'h2800000
`define IO_BASE        26'h3000000
`define SHARED_BASE    26'h3400000
`define XLATE_WR_BASE  26'h3800000

// field positions
`define PAGE_LSB       15
`define WORD_LSB       2
`define XW_BANK_BIT    7
`define XW_PROT_LSB    8
`define XW_LPN_LSB     13

// reset values
`define PPN_RESET      7'h00
`define ROW_RESET      10'h000

`endif

// ==== page_xlate_pkg.sv ====
package page_xlate_pkg;

   // one processor request, latched at the end of the announcing cycle
   typedef struct packed {
      logic        valid;
      logic [25:0] addr;
      logic        rw;
      logic        user;
      logic        os;
   } cpu_req_s;

   // one translation entry, indexed by its physical page
   typedef struct packed {
      logic [9:0] lpn;
      logic [1:0] prot;
   } xlate_entry_s;

   typedef struct packed {
      logic [127:0] valid;
   } cam_state_s;

   typedef struct packed {
      logic [2:0]  cnt;
      logic        ph1;
      logic        ph2;
      logic        strap_done;
      logic        is_master;
      cpu_req_s    req;
      logic        vote;
      logic        go;
      logic        abort;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [9:0]  dram_addr;
      logic [9:0]  open_row;
      logic [9:0]  acc_col;
   } mgr_state_s;

endpackage

// ==== processor_model.sv ====
`timescale 1ns/100ps

module processor_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_phase_two_clock,
   output logic [25:0]      o_addr,
   output logic             o_read_write,
   output logic             o_opcode_fetch_n,
   output logic             o_memory_request_n,
   output logic             o_translate_n,
   output logic             o_os_mode
);
   logic        pend;
   logic        ph2_ff;
   logic [25:0] cmd_addr;
   logic        cmd_rw;
   logic        cmd_tn;
   logic        cmd_os;

   // idle bus at time zero, supervisor mode
   initial begin
      pend               = 1'b0;
      ph2_ff             = 1'b0;
      o_addr             = 26'h0000000;
      o_read_write       = 1'b0;
      o_opcode_fetch_n   = 1'b1;
      o_memory_request_n = 1'b1;
      o_translate_n      = 1'b1;
      o_os_mode          = 1'b0;
   end

   // queue one data cycle; it leaves at the next start of phase two
   task automatic post(input logic [25:0] a, input logic w, input logic t, input logic o);
      cmd_addr = a;
      cmd_rw   = w;
      cmd_tn   = t;
      cmd_os   = o;
      pend     = 1'b1;
   endtask

   // launch in phase two of the announcing cycle, hold through the next phase one
   always @(negedge i_ref_clk) begin
      if (i_phase_two_clock === 1'b1 && ph2_ff === 1'b0) begin
         if (pend) begin
            o_addr             = cmd_addr;
            o_read_write       = cmd_rw;
            o_opcode_fetch_n   = 1'b1;
            o_memory_request_n = 1'b0;
            o_translate_n      = cmd_tn;
            o_os_mode          = cmd_os;
            pend               = 1'b0;
         end else begin
            // released address and read/write lines never keep a stale, still-valid looking value
            o_addr             = ~o_addr;
            o_read_write       = ~o_read_write;
            o_memory_request_n = 1'b1;
         end
      end
      ph2_ff = i_phase_two_clock;
   end
endmodule
